//--- logic/mhi_pkg.sv
`default_nettype none
package mhi_pkg;
  // host port map (address bit 0 within the pair)
  localparam logic ADDR_DATA = 1'h0;
  localparam logic ADDR_CTRL = 1'h1;
  localparam int DATA_W = 8;
  // status layout and reset value
  localparam int STAT_EMPTY_BIT = 7;
  localparam int STAT_BUSY_BIT = 6;
  localparam logic [7:0] STAT_RESET = 8'h80;
  localparam logic [5:0] STAT_RSVD = 6'h00;
  // command codes and acknowledge
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_PASS = 8'h3f;
  localparam logic [7:0] ACK_BYTE = 8'hfe;
  localparam logic [7:0] NO_DATA = 8'h00;
  // serial timing
  localparam int CLK_NS = 20;
  localparam int BIT_NS = 32000;
  localparam int BIT_CYC = BIT_NS / CLK_NS;
  localparam int OVS = 16;
  localparam int TICK_CYC = BIT_CYC / OVS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
  localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
  localparam logic [3:0] OVS_MID = 4'(OVS / 2 - 1);
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int FIFO_DEPTH = 16;
  // serial framer states, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_START = 2'h1,
    SER_DATA = 2'h3,
    SER_STOP = 2'h2
  } mhi_ser_state_t;
endpackage : mhi_pkg
`default_nettype wire

//--- logic/mhi_top.sv
// Notes on behaviour
// R1 - status read-only: bit6 tx busy, bit7 rx empty, low bits zero, resets 0x80
// R2 - rx empty reads 0 while a received or acknowledge byte waits
// R3 - interrupt high while rx empty is 0, low while it is 1
// R4 - tx busy 0 when a byte can be accepted; host writes only then
// R5 - no transmit condition or line status ever touches the interrupt
// R6 - write at base plus one is a command; read there returns status
// R7 - data read drops interrupt unless more received bytes remain
// R8 - interrupt held low while activate is 0
// R9 - act at once on FFh and 3Fh, ignore every other code; code still sets tx busy for a cycle on other codes
// R10 - reset command leaves pass-through, stops link, flushes rx, acks if idle
// R11 - reset while in pass-through does the reset but queues no ack
// R12 - in reset state serial input and host data writes are dropped
// R13 - reset state entered after power-on reset and after reset command
// R14 - pass command flushes both FIFOs, queues FEh, enables the link
// R15 - in pass-through data goes unmodified both directions
// R16 - pass command while in pass-through is ignored completely; code still sets tx busy for the next cycle
// R17 - ack read before FIFO data; flush happens before ack placed
// R18 - link 31.25k baud, 10-bit frame: start, 8 data, stop
// R19 - serial bytes go out and come in LSB first
// R20 - full duplex with 16-byte transmit and receive FIFOs
// R21 - data port write is transmit byte, read gives rx or ack byte
// R22 - activate 0 disables decode and parks the block
// R23 - tx busy while tx FIFO full or a command is processing
// R24 - bit timing from an integer divider of the system clock
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// synchronous fifo, power-of-two depth
module mhi_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  input wire logic out_ready_in,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // flush beats a same-cycle push: the byte is dropped on purpose
  always_comb begin
    in_ready_out = (cnt_q != (AW+1)'(DEPTH));
    out_valid_out = (cnt_q != '0);
    out_data_out = mem_q[rd_q];
    push = in_valid_in & in_ready_out;
    pop = out_valid_out & out_ready_in;
    wr_d = wr_q + AW'(push);
    rd_d = rd_q + AW'(pop);
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_in) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset, only valid entries are ever read
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end
endmodule : mhi_fifo

////////////////////////////////////////////////////////////////////////////////
module mhi_top (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic activate_in,
  input wire logic addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [mhi_pkg::DATA_W-1:0] wdata_in,
  output logic [mhi_pkg::DATA_W-1:0] rdata_out,
  output logic irq_out,
  input wire logic serial_music_input_in,
  output logic serial_music_output_out
);
  import mhi_pkg::*;

  logic pass_q, pass_d, ack_q, ack_d, cmd_busy_q, cmd_busy_d;
  logic [7:0] rdata_q, rdata_d;
  logic rd, wr, cmd_wr, dat_wr, dat_rd, do_reset, do_pass, flush;
  logic rx_empty_flag, tx_busy_flag;
  logic [7:0] status;
  logic tx_in_ready, tx_valid, tx_pop;
  logic [7:0] tx_data;
  logic rx_in_ready, rx_valid, rx_pop, rx_push;
  logic [7:0] rx_data;
  logic [6:0] tick_q, tick_d;
  logic tick;
  mhi_ser_state_t tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
  logic [2:0] tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d;
  logic [3:0] tx_os_q, tx_os_d, rx_os_q, rx_os_d;
  logic tx_line_q, tx_line_d;

  //////////////////////////////////////////////////////////////////////////////
  // host port decode and command controller
  always_comb begin
    // R22 decode gated by activate
    rd = activate_in & rd_in;
    wr = activate_in & wr_in;
    // R6 command write at base plus one
    cmd_wr = wr & (addr_in == ADDR_CTRL);
    dat_wr = wr & (addr_in == ADDR_DATA);
    dat_rd = rd & (addr_in == ADDR_DATA);
    // R9 two codes only, acted on in the write cycle
    do_reset = cmd_wr & (wdata_in == CMD_RESET);
    // R16 pass command ignored when already passing
    do_pass = cmd_wr & (wdata_in == CMD_PASS) & !pass_q;
    // R17 flush takes both FIFOs, the ack flag is separate and survives
    flush = do_reset | do_pass;
    // R10 reset leaves pass-through, R14 pass enters it
    pass_d = pass_q;
    if (do_reset) begin
      pass_d = 1'h0;
    end else if (do_pass) begin
      pass_d = 1'h1;
    end
    // R17 ack served ahead of fifo data; set wins over the read clear
    ack_d = ack_q;
    if (dat_rd) begin
      ack_d = 1'h0;
    end
    // R11 no ack for reset inside pass-through
    if ((do_reset & !pass_q) | do_pass) begin
      ack_d = 1'h1;
    end
    // R23 busy one cycle after any command
    cmd_busy_d = cmd_wr;
    // R7 a data read pops the ack first, else one fifo byte
    rx_pop = dat_rd & !ack_q;
    // R2 empty only when neither ack nor fifo byte waits
    rx_empty_flag = !(ack_q | rx_valid);
    // R4 busy when a write would be lost
    tx_busy_flag = !tx_in_ready | cmd_busy_q;
    // R1 reserved bits read zero
    status = {rx_empty_flag, tx_busy_flag, STAT_RSVD};
    // R21 data port read returns ack, fifo byte or zero
    rdata_d = rdata_q;
    if (rd) begin
      if (addr_in == ADDR_CTRL) begin
        rdata_d = status;
      end else if (ack_q) begin
        rdata_d = ACK_BYTE;
      end else if (rx_valid) begin
        rdata_d = rx_data;
      end else begin
        rdata_d = NO_DATA;
      end
    end
  end

  // R13 power-on reset lands in the reset state
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pass_q <= 1'h0;
      ack_q <= 1'h0;
      cmd_busy_q <= 1'h0;
      rdata_q <= NO_DATA;
    end else begin
      pass_q <= pass_d;
      ack_q <= ack_d;
      cmd_busy_q <= cmd_busy_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;
  // R3 level interrupt, R8 masked by activate, R5 no tx term
  assign irq_out = activate_in & !rx_empty_flag;
  assign serial_music_output_out = tx_line_q;

  //////////////////////////////////////////////////////////////////////////////
  // R20 sixteen-byte fifos each way
  mhi_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .flush_in(flush),
    // R12 host data dropped outside pass-through, R15 unmodified
    .in_valid_in(dat_wr & pass_q),
    .in_data_in(wdata_in),
    .in_ready_out(tx_in_ready),
    .out_ready_in(tx_pop),
    .out_valid_out(tx_valid),
    .out_data_out(tx_data)
  );

  mhi_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .flush_in(flush),
    .in_valid_in(rx_push),
    .in_data_in(rx_sh_q),
    .in_ready_out(rx_in_ready),
    .out_ready_in(rx_pop),
    .out_valid_out(rx_valid),
    .out_data_out(rx_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // R24 oversample divider, 1600 clocks per bit split into 16 ticks
  always_comb begin
    tick = (tick_q == TICK_LAST);
    tick_d = tick ? 7'h00 : tick_q + 7'h01;
    // parked while deactivated to save power
    if (!activate_in) begin
      tick_d = 7'h00;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tick_q <= 7'h00;
    end else begin
      tick_q <= tick_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmitter; frames start on a tick so every bit is 16 ticks
  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_bit_d = tx_bit_q;
    tx_os_d = tx_os_q;
    tx_line_d = tx_line_q;
    tx_pop = 1'h0;
    if (tick) begin
      tx_os_d = tx_os_q + 4'h1;
    end
    unique case (tx_st_q)
      SER_IDLE: begin
        tx_line_d = 1'h1;
        if (tick & tx_valid) begin
          tx_pop = 1'h1;
          tx_sh_d = tx_data;
          tx_os_d = 4'h0;
          tx_line_d = 1'h0;
          tx_st_d = SER_START;
        end
      end
      SER_START: begin
        if (tick & (tx_os_q == OVS_LAST)) begin
          // R19 lsb leaves first
          tx_line_d = tx_sh_q[0];
          tx_bit_d = 3'h0;
          tx_st_d = SER_DATA;
        end
      end
      SER_DATA: begin
        if (tick & (tx_os_q == OVS_LAST)) begin
          tx_bit_d = tx_bit_q + 3'h1;
          tx_sh_d = {1'h0, tx_sh_q[7:1]};
          tx_line_d = tx_sh_q[1];
          // R18 eight data bits then one stop bit
          if (tx_bit_q == BIT_LAST) begin
            tx_line_d = 1'h1;
            tx_st_d = SER_STOP;
          end
        end
      end
      SER_STOP: begin
        if (tick & (tx_os_q == OVS_LAST)) begin
          tx_st_d = SER_IDLE;
        end
      end
    endcase
    // R10 link disabled outside pass-through, frame in flight is cut
    if (!pass_q) begin
      tx_st_d = SER_IDLE;
      tx_line_d = 1'h1;
      tx_pop = 1'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tx_st_q <= SER_IDLE;
      tx_sh_q <= 8'h00;
      tx_bit_q <= 3'h0;
      tx_os_q <= 4'h0;
      tx_line_q <= 1'h1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_bit_q <= tx_bit_d;
      tx_os_q <= tx_os_d;
      tx_line_q <= tx_line_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver; start found within one tick, bits sampled mid-cell
  always_comb begin
    rx_st_d = rx_st_q;
    rx_sh_d = rx_sh_q;
    rx_bit_d = rx_bit_q;
    rx_os_d = rx_os_q;
    rx_push = 1'h0;
    if (tick) begin
      rx_os_d = rx_os_q + 4'h1;
    end
    unique case (rx_st_q)
      SER_IDLE: begin
        if (tick & !serial_music_input_in) begin
          rx_os_d = 4'h0;
          rx_st_d = SER_START;
        end
      end
      SER_START: begin
        if (tick & (rx_os_q == OVS_MID)) begin
          rx_os_d = 4'h0;
          rx_bit_d = 3'h0;
          // glitch shorter than half a bit is not a start
          rx_st_d = serial_music_input_in ? SER_IDLE : SER_DATA;
        end
      end
      SER_DATA: begin
        if (tick & (rx_os_q == OVS_LAST)) begin
          // R19 lsb arrives first, shifted in from the top
          rx_sh_d = {serial_music_input_in, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == BIT_LAST) begin
            rx_st_d = SER_STOP;
          end
        end
      end
      SER_STOP: begin
        if (tick & (rx_os_q == OVS_LAST)) begin
          // bad stop bit or full fifo drops the byte silently
          rx_push = serial_music_input_in;
          rx_st_d = SER_IDLE;
        end
      end
    endcase
    // R12 serial input ignored in the reset state
    if (!pass_q) begin
      rx_st_d = SER_IDLE;
      rx_push = 1'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rx_st_q <= SER_IDLE;
      rx_sh_q <= 8'h00;
      rx_bit_q <= 3'h0;
      rx_os_q <= 4'h0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_sh_q <= rx_sh_d;
      rx_bit_q <= rx_bit_d;
      rx_os_q <= rx_os_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_STATUS_LAYOUT: assert property ( // R1
    rd & (addr_in == ADDR_CTRL) |=> (rdata_out[5:0] == STAT_RSVD)
      && (rdata_out[STAT_EMPTY_BIT] == !($past(ack_q) | $past(rx_valid))))
    else $error("status read layout wrong");
  // irq seen at a status read must match the empty bit that read returns
  AST_IRQ_LEVEL: assert property ( // R3
    rd & (addr_in == ADDR_CTRL) |=> ($past(irq_out) == !rdata_out[STAT_EMPTY_BIT]))
    else $error("irq does not follow rx empty");
  AST_IRQ_STAYS: assert property ( // R7
    dat_rd & ack_q & rx_valid |=> !rx_empty_flag && rx_valid)
    else $error("irq dropped with fifo data left");
  AST_BUSY_CMD: assert property ( // R23
    cmd_wr |=> status[STAT_BUSY_BIT])
    else $error("busy clear right after command");
  AST_IRQ_INACTIVE: assert property ( // R8
    !activate_in |-> !irq_out)
    else $error("irq high while deactivated");
  AST_TX_NO_IRQ: assert property ( // R5
    dat_wr & !ack_q & !rx_valid & !rx_push |=> !irq_out)
    else $error("data write raised irq");
  AST_RESET_ACK: assert property ( // R10
    do_reset & !pass_q |=> ack_q & !pass_q & !rx_valid & !tx_valid)
    else $error("reset command ack or flush missing");
  AST_RESET_NOACK: assert property ( // R11
    do_reset & pass_q & !ack_q |=> !ack_q & !pass_q & !rx_valid)
    else $error("reset in pass-through misbehaved");
  AST_PASS_ENTER: assert property ( // R14
    do_pass |=> pass_q & ack_q & !rx_valid & !tx_valid)
    else $error("pass command effect missing");
  AST_PASS_IGNORED: assert property ( // R16
    cmd_wr & (wdata_in == CMD_PASS) & pass_q |=> pass_q && $stable(ack_q))
    else $error("repeated pass command not ignored");
  AST_ACK_FIRST: assert property ( // R17
    dat_rd & ack_q |=> (rdata_out == ACK_BYTE) && !ack_q)
    else $error("ack not returned first");
  AST_DISCARD: assert property ( // R12
    !pass_q |-> !tx_valid && !rx_push)
    else $error("data kept in reset state");
  AST_FRAME_LEVELS: assert property ( // R18
    (tx_st_q == SER_START |-> !serial_music_output_out)
      and (tx_st_q == SER_STOP |-> serial_music_output_out))
    else $error("start or stop level wrong");
  AST_BUSY_FULL: assert property ( // R23
    !tx_in_ready |-> status[STAT_BUSY_BIT])
    else $error("busy clear while tx fifo full");

  COV_PASS: cover property (do_pass ##1 pass_q);
  COV_ACK_READ: cover property (dat_rd & ack_q);
  COV_RX_BYTE: cover property (rx_push ##[1:20] dat_rd);
  COV_TX_FRAME: cover property (tx_pop);
  // rx overflow drops bytes silently, worth seeing once
  COV_RX_FULL: cover property (!rx_in_ready);
endmodule : mhi_top
`default_nettype wire

//--- tb/mhi_link_partner.sv
`timescale 1ns/1ns
`default_nettype none
// music device on the far end of the serial link, timed in ns
module mhi_link_partner (
  input wire logic line_from_dut_in,
  output logic line_to_dut_out
);
  localparam int BIT_T = 32000;
  logic [7:0] got_q;
  int got_count;
  int frame_errs;
  initial begin
    line_to_dut_out = 1'h1;
    got_count = 0;
    frame_errs = 0;
  end
  ////////////////////////////////////////////////////////////
  // frame lsb first
  task automatic send_byte(input logic [7:0] b);
    line_to_dut_out = 1'h0;
    #BIT_T;
    for (int i = 0; i < 8; i++) begin
      line_to_dut_out = b[i];
      #BIT_T;
    end
    line_to_dut_out = 1'h1;
    #BIT_T;
  endtask : send_byte
  always begin
    @(negedge line_from_dut_in);
    #(BIT_T / 2);
    if (line_from_dut_in !== 1'h0) frame_errs++;
    for (int i = 0; i < 8; i++) begin
      #BIT_T;
      got_q[i] = line_from_dut_in;
    end
    #BIT_T;
    if (line_from_dut_in !== 1'h1) frame_errs++;
    got_count++;
  end
endmodule : mhi_link_partner
`default_nettype wire

//--- tb/midi_host_interface_test.sv
`timescale 1ns/1ns
`default_nettype none
module midi_host_interface_test;
  import mhi_pkg::*;
  logic clk_in, rstn_in, activate_in, addr_in, rd_in, wr_in, irq_out, ser_in, ser_out;
  logic [DATA_W-1:0] wdata_in;
  logic [DATA_W-1:0] rdata_out;
  int fail_count, tests_run, cycles;
  mhi_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .activate_in(activate_in),
    .addr_in(addr_in), .rd_in(rd_in), .wr_in(wr_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .serial_music_input_in(ser_in),
    .serial_music_output_out(ser_out));
  mhi_link_partner partner_u (.line_from_dut_in(ser_out), .line_to_dut_out(ser_in));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // requests change 2 ns after the edge and hold one full cycle
  task automatic bus_write(input logic a, input logic [7:0] d);
    @(posedge clk_in);
    #2;
    addr_in = a;
    wdata_in = d;
    wr_in = 1'h1;
    @(posedge clk_in);
    #2;
    wr_in = 1'h0;
  endtask : bus_write
  task automatic bus_read(input logic a, input string what, input logic [7:0] exp);
    @(posedge clk_in);
    #2;
    addr_in = a;
    rd_in = 1'h1;
    @(posedge clk_in);
    #2;
    rd_in = 1'h0;
    check(what, rdata_out, exp);
  endtask : bus_read
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : wait_cyc
  // bounded wait, a late byte shows as a mismatch
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_out !== 1'h1 && n < 2000) begin
      wait_cyc(1);
      n++;
    end
  endtask : wait_irq
  ////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    check("irq", {7'h0, irq_out}, 8'h00);
    bus_read(1'h1, "status", STAT_RESET);
    bus_read(1'h0, "data idle", NO_DATA);
    bus_write(1'h1, 8'h12);
    wait_cyc(2);
    check("irq", {7'h0, irq_out}, 8'h00);
    bus_read(1'h1, "status", STAT_RESET);
    $display("test reset_values done");
  endtask : t_reset_values
  task automatic t_cmd_idle();
    bus_write(1'h1, CMD_RESET);
    check("irq", {7'h0, irq_out}, 8'h01);
    bus_read(1'h1, "status", 8'h00);
    bus_read(1'h0, "ack", ACK_BYTE);
    check("irq", {7'h0, irq_out}, 8'h00);
    bus_write(1'h0, 8'h55);
    wait_cyc(150);
    check("line", {7'h0, ser_out}, 8'h01);
    $display("test cmd_idle done");
  endtask : t_cmd_idle
  task automatic t_pass_duplex();
    bus_write(1'h1, CMD_PASS);
    bus_read(1'h0, "ack", ACK_BYTE);
    bus_write(1'h1, CMD_PASS);
    wait_cyc(2);
    check("irq", {7'h0, irq_out}, 8'h00);
    fork
      bus_write(1'h0, 8'ha5);
      partner_u.send_byte(8'h3c);
    join
    wait_irq();
    wait_cyc(1700);
    check("tx byte", partner_u.got_q, 8'ha5);
    check("frame", 8'(partner_u.frame_errs), 8'h00);
    check("frames", 8'(partner_u.got_count), 8'h01);
    check("irq", {7'h0, irq_out}, 8'h01);
    bus_read(1'h0, "rx byte", 8'h3c);
    check("irq", {7'h0, irq_out}, 8'h00);
    $display("test pass_duplex done");
  endtask : t_pass_duplex
  task automatic t_fill();
    bus_write(1'h0, 8'h01);
    wait_cyc(200);
    for (int i = 0; i < FIFO_DEPTH; i++) bus_write(1'h0, 8'(i));
    bus_read(1'h1, "status full", 8'hc0);
    check("irq", {7'h0, irq_out}, 8'h00);
    // host holds off until a frame frees a slot
    wait_cyc(16000);
    bus_read(1'h1, "status slot", STAT_RESET);
    bus_write(1'h1, CMD_RESET);
    wait_cyc(2);
    bus_read(1'h1, "status", STAT_RESET);
    $display("test fill done");
  endtask : t_fill
  task automatic t_drop_rx();
    partner_u.send_byte(8'h5a);
    wait_cyc(200);
    check("irq", {7'h0, irq_out}, 8'h00);
    $display("test drop_rx done");
  endtask : t_drop_rx
  task automatic t_deactivate();
    bus_write(1'h1, CMD_PASS);
    partner_u.send_byte(8'h96);
    wait_irq();
    bus_read(1'h0, "ack first", ACK_BYTE);
    check("irq stays", {7'h0, irq_out}, 8'h01);
    activate_in = 1'h0;
    #1;
    check("irq off", {7'h0, irq_out}, 8'h00);
    bus_write(1'h1, CMD_RESET);
    activate_in = 1'h1;
    #1;
    check("irq on", {7'h0, irq_out}, 8'h01);
    bus_write(1'h1, CMD_RESET);
    wait_cyc(2);
    check("irq", {7'h0, irq_out}, 8'h00);
    bus_read(1'h0, "data", NO_DATA);
    $display("test deactivate done");
  endtask : t_deactivate
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("counts run %0d bad %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // cut a hang: the run needs roughly 70k cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      $display("BAD timeout");
      finish_test();
    end
  end
  initial begin
    clk_in = 1'h0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    rstn_in = 1'h0;
    activate_in = 1'h1;
    addr_in = 1'h0;
    rd_in = 1'h0;
    wr_in = 1'h0;
    wdata_in = 8'h00;
    wait_cyc(20);
    rstn_in = 1'h1;
    t_reset_values();
    t_cmd_idle();
    t_pass_duplex();
    t_fill();
    t_drop_rx();
    t_deactivate();
    finish_test();
  end
endmodule : midi_host_interface_test
`default_nettype wire
